// [hdl/dac_mode_control.sv]
// mode control of a stereo dac: serial control port, registers, mute ramp
// assumes all pins are asynchronous to clock, a 200 MHz system clock
//
// Overview of operation
// - mute request ramps attenuation up over 1024 frames
// - mute release ramps attenuation back to 0dB
// - early release reverses ramp from current level
// - power-down pin low: power down, outputs floating
// - wait for both clocks, start on frame rise
// - format, ratio, speed: pin ORed with register
// - serial port only when serial/parallel select low
// - sample data on control clock rising edge
// - commit register on chip select rising edge
// - power-down pin low restores register defaults
// - timing reset bit resets timing only
// - ignore writes in power-down or without master clock
// - write only, fixed prefix 011
// - register 00H layout and default 01H
// - register 01H layout and default zero
// - speed bit: 0 normal, 1 double; modes default 0
// - format codes: 16 LSB, 20 LSB, 24 MSB, I2S, 24 LSB
// - de-emphasis decode depends on speed
// - ratio codes map to master clock ratios
`timescale 1ns/1ps
`include "dac_mode_consts.svh"
module dac_mode_control #(
    parameter int RAMP_CYCLES   = `MUTE_RAMP_CYCLES,
    parameter int MCLK_TIMEOUT  = `MCLK_TIMEOUT_CYCLES,
    parameter int FCLK_TIMEOUT  = `FCLK_TIMEOUT_CYCLES
) (
    // system clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // device pins
    input  wire logic              power_down_pin_n,
    input  wire logic              serialSelectN,
    input  wire logic              masterClock,
    input  wire logic              frame_clock,
    // mode pins; format, ratio and speed ORed with register bits, de-emphasis and mute used outside serial mode
    input  wire logic [2:0]        formatPins,
    input  wire logic [2:0]        ratioPins,
    input  wire logic              speedPin,
    input  wire logic [1:0]        deemphPins,
    input  wire logic              mutePin,
    // three-wire control port
    input  wire logic              control_select_n,
    input  wire logic              control_clock,
    input  wire logic              control_data_in,
    // decoded settings
    output dac_mode_pkg::format_t  format_select,
    output logic [2:0]             clock_ratio_select,
    output logic [9:0]             ratioFs,
    output logic                   speed_select,
    output dac_mode_pkg::deemph_t  deemphasis_select,
    // state to the audio path
    output logic                   poweredUp,
    output logic                   timingRunN,
    output logic                   analogOutEnN,
    output logic [10:0]            attenuation,
    output logic                   muteDone
);
    import dac_mode_pkg::*;

    localparam int AW = $clog2(RAMP_CYCLES + 1);
    localparam int MW = $clog2(MCLK_TIMEOUT + 1);
    localparam int LW = $clog2(FCLK_TIMEOUT + 1);

    // ****************************************************
    // reset release and pin synchronisers
    // ****************************************************
    logic rstMeta_q;
    logic rstSync_q;
    logic resetN;

    // async assert, two-flop release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    assign resetN = rstSync_q;

    logic pwrLvl, serLvl, mclkRise, fclkRise, cselLvl, cselRise;
    logic cselFall, sclkRise, cdatLvl, muteLvl, spdLvl;
    logic [2:0] fmtLvl, ratLvl;
    logic [1:0] demLvl;

    // one synchroniser per asynchronous pin
    edge_sync pwrS  (.clock(clock), .resetN(resetN),
        .pinIn(power_down_pin_n), .level(pwrLvl), .rise(), .fall());
    edge_sync serS  (.clock(clock), .resetN(resetN),
        .pinIn(serialSelectN), .level(serLvl), .rise(), .fall());
    edge_sync mclkS (.clock(clock), .resetN(resetN),
        .pinIn(masterClock), .level(), .rise(mclkRise), .fall());
    edge_sync fclkS (.clock(clock), .resetN(resetN),
        .pinIn(frame_clock), .level(), .rise(fclkRise), .fall());
    edge_sync cselS (.clock(clock), .resetN(resetN),
        .pinIn(control_select_n), .level(cselLvl), .rise(cselRise),
        .fall(cselFall));
    edge_sync sclkS (.clock(clock), .resetN(resetN),
        .pinIn(control_clock), .level(), .rise(sclkRise), .fall());
    edge_sync cdatS (.clock(clock), .resetN(resetN),
        .pinIn(control_data_in), .level(cdatLvl), .rise(), .fall());
    edge_sync muteS (.clock(clock), .resetN(resetN),
        .pinIn(mutePin), .level(muteLvl), .rise(), .fall());
    edge_sync spdS  (.clock(clock), .resetN(resetN),
        .pinIn(speedPin), .level(spdLvl), .rise(), .fall());

    // format and ratio buses share one generate loop of synchronisers; de-emphasis has its own
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : modeSync
            edge_sync fS (.clock(clock), .resetN(resetN),
                .pinIn(formatPins[g]), .level(fmtLvl[g]), .rise(), .fall());
            edge_sync rS (.clock(clock), .resetN(resetN),
                .pinIn(ratioPins[g]), .level(ratLvl[g]), .rise(), .fall());
        end
        for (g = 0; g < 2; g++) begin : demSync
            edge_sync dS (.clock(clock), .resetN(resetN),
                .pinIn(deemphPins[g]), .level(demLvl[g]), .rise(), .fall());
        end
    endgenerate

    // ****************************************************
    // clock presence detection
    // ****************************************************
    logic [MW-1:0] mclkAge_q;
    logic [LW-1:0] fclkAge_q;
    logic          mclkPresent;
    logic          fclkPresent;

    // age counters restart on each rising edge and saturate at the timeout
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            mclkAge_q <= MW'(MCLK_TIMEOUT);
            fclkAge_q <= LW'(FCLK_TIMEOUT);
        end else begin
            if (mclkRise)
                mclkAge_q <= '0;
            else if (mclkAge_q != MW'(MCLK_TIMEOUT))
                mclkAge_q <= mclkAge_q + 1'b1;
            if (fclkRise)
                fclkAge_q <= '0;
            else if (fclkAge_q != LW'(FCLK_TIMEOUT))
                fclkAge_q <= fclkAge_q + 1'b1;
        end
    end
    assign mclkPresent = (mclkAge_q != MW'(MCLK_TIMEOUT));
    assign fclkPresent = (fclkAge_q != LW'(FCLK_TIMEOUT));

    // ****************************************************
    // serial control port
    // ****************************************************
    logic [15:0] shift_q;
    logic [4:0]  bitCount_q;
    logic        frameOpen_q;
    logic        serialMode;
    logic        commit;

    assign serialMode = ~serLvl;
    // frame opens on select fall; bits taken on control clock rise
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            shift_q     <= '0;
            bitCount_q  <= '0;
            frameOpen_q <= 1'b0;
        end else if (cselFall) begin
            bitCount_q  <= '0;
            frameOpen_q <= 1'b1;
        end else if (cselRise) begin
            frameOpen_q <= 1'b0;
        end else if (frameOpen_q && !cselLvl && sclkRise) begin
            shift_q <= {shift_q[14:0], cdatLvl};
            if (bitCount_q != `FRAME_BITS)
                bitCount_q <= bitCount_q + 1'b1;
        end
    end

    // write taken only on select rise with full frame and good prefix
    assign commit = cselRise && frameOpen_q && serialMode
        && bitCount_q == `FRAME_BITS
        && shift_q[15:13] == `FRAME_PREFIX
        && pwrLvl && mclkPresent;

    // ****************************************************
    // registers
    // ****************************************************
    logic [7:0] clockFormat_q;
    logic [7:0] speedMute_q;
    logic [7:0] factoryTest_q;

    // power-down pin returns every register to default
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            clockFormat_q <= `RESET_CLOCK_FORMAT;
            speedMute_q   <= `RESET_SPEED_MUTE;
            factoryTest_q <= `RESET_FACTORY_TEST;
        end else if (!pwrLvl) begin
            clockFormat_q <= `RESET_CLOCK_FORMAT;
            speedMute_q   <= `RESET_SPEED_MUTE;
            factoryTest_q <= `RESET_FACTORY_TEST;
        end else if (commit) begin
            unique case (shift_q[12:8])
                `ADDR_CLOCK_FORMAT: clockFormat_q <= {1'b0, shift_q[6:0]};
                `ADDR_SPEED_MUTE:   speedMute_q   <= {4'h0, shift_q[3:0]};
                `ADDR_FACTORY_TEST: factoryTest_q <= shift_q[7:0];
                default: ; // unmapped addresses ignored
            endcase
        end
    end

    // ****************************************************
    // mode decode
    // ****************************************************
    logic [2:0] fmtEff, ratEff;
    logic       spdEff;
    logic [1:0] demEff;
    logic       muteReq;

    // pins ORed with register bits in either mode
    assign fmtEff = fmtLvl | clockFormat_q[`FORMAT_LSB +: 3];
    assign ratEff = ratLvl | clockFormat_q[`RATIO_LSB +: 3];
    assign spdEff = spdLvl | speedMute_q[`SPEED_BIT];
    // de-emphasis and mute come from register in serial mode, else pins
    assign demEff = serialMode ? speedMute_q[`DEEMPH_LSB +: 2] : demLvl;
    assign muteReq = serialMode ? speedMute_q[`MUTE_BIT] : muteLvl;

    // decoded settings registered straight to outputs
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            format_select      <= FMT_LSB16;
            clock_ratio_select <= 3'h0;
            ratioFs            <= 10'h100;
            speed_select       <= 1'b0;
            deemphasis_select  <= DEEMPH_441K;
        end else begin
            unique case (fmtEff)
                3'h0: format_select <= FMT_LSB16;
                3'h1: format_select <= FMT_LSB20;
                3'h2: format_select <= FMT_MSB24;
                3'h3: format_select <= FMT_I2S;
                default: format_select <= FMT_LSB24; // codes above 4 alias
            endcase
            clock_ratio_select <= ratEff;
            speed_select       <= spdEff;
            // zero marks a ratio with no valid double-speed use
            unique case ({spdEff, ratEff})
                4'h0, 4'h1:       ratioFs <= 10'h100;
                4'h2, 4'h3:       ratioFs <= 10'h180;
                4'h4, 4'h5:       ratioFs <= 10'h200;
                4'h6, 4'h7:       ratioFs <= 10'h300;
                4'h8:             ratioFs <= 10'h080;
                4'h9, 4'hc:       ratioFs <= 10'h100;
                4'ha:             ratioFs <= 10'h0c0;
                4'hb, 4'he:       ratioFs <= 10'h180;
                default:          ratioFs <= 10'h000;
            endcase
            unique case ({spdEff, demEff})
                3'h0: deemphasis_select <= DEEMPH_441K;
                3'h2: deemphasis_select <= DEEMPH_48K;
                3'h3: deemphasis_select <= DEEMPH_32K;
                3'h6: deemphasis_select <= DEEMPH_96K;
                default: deemphasis_select <= DEEMPH_OFF;
            endcase
        end
    end

    // ****************************************************
    // power and timing sequencing
    // ****************************************************
    power_t powerState_q;

    // hold powered down until both clocks run, then start on frame rise
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            powerState_q <= POWER_DOWN;
        end else if (!pwrLvl) begin
            powerState_q <= POWER_DOWN;
        end else begin
            unique case (powerState_q)
                POWER_DOWN:  powerState_q <= WAIT_CLOCKS;
                WAIT_CLOCKS: if (mclkPresent && fclkPresent)
                    powerState_q <= WAIT_FRAME;
                WAIT_FRAME:  if (!mclkPresent || !fclkPresent)
                    powerState_q <= WAIT_CLOCKS;
                else if (fclkRise)
                    powerState_q <= RUNNING;
                RUNNING:     if (!mclkPresent || !fclkPresent)
                    powerState_q <= WAIT_CLOCKS;
            endcase
        end
    end

    // timing reset bit gates timing only; registers keep their values
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            poweredUp    <= 1'b0;
            timingRunN   <= 1'b0;
            analogOutEnN <= 1'b1;
        end else begin
            poweredUp    <= (powerState_q == RUNNING);
            timingRunN   <= (powerState_q == RUNNING)
                && clockFormat_q[`TIMING_RESET_BIT];
            analogOutEnN <= !pwrLvl;
        end
    end

    // ****************************************************
    // soft mute ramp
    // ****************************************************
    logic [AW-1:0] ramp_q;

    // one step per frame rise, either direction; reversal is immediate
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            ramp_q <= '0;
        end else if (powerState_q != RUNNING) begin
            ramp_q <= muteReq ? AW'(RAMP_CYCLES) : '0;
        end else if (fclkRise) begin
            if (muteReq && ramp_q != AW'(RAMP_CYCLES))
                ramp_q <= ramp_q + 1'b1;
            else if (!muteReq && ramp_q != '0)
                ramp_q <= ramp_q - 1'b1;
        end
    end

    // attenuation step count out, zero is 0dB, full count is full mute
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            attenuation <= '0;
            muteDone    <= 1'b0;
        end else begin
            attenuation <= 11'(ramp_q);
            muteDone    <= (ramp_q == AW'(RAMP_CYCLES));
        end
    end
endmodule

// [hdl/dac_mode_consts.svh]
// constants for the dac mode control block: offsets, fields, resets, timing
// assumes inclusion by bare name from design files
`ifndef DAC_MODE_CONSTS_SVH
`define DAC_MODE_CONSTS_SVH

// register addresses on the control port
`define ADDR_CLOCK_FORMAT     5'h00
`define ADDR_SPEED_MUTE       5'h01
`define ADDR_FACTORY_TEST     5'h02
// fixed frame prefix: chip address 01, direction 1
`define FRAME_PREFIX          3'h3
`define FRAME_BITS            5'h10
// reset values
`define RESET_CLOCK_FORMAT    8'h01
`define RESET_SPEED_MUTE      8'h00
`define RESET_FACTORY_TEST    8'h00
// field positions
`define TIMING_RESET_BIT      0
`define FORMAT_LSB            1
`define RATIO_LSB             4
`define MUTE_BIT              0
`define DEEMPH_LSB            1
`define SPEED_BIT             3
// soft mute ramp length in frame-clock cycles
`define MUTE_RAMP_CYCLES      1024
// master clock deemed absent after this many system clocks without an edge
`define MCLK_TIMEOUT_CYCLES   64
// frame clock deemed absent after this many clocks (above the 33 us frame)
`define FCLK_TIMEOUT_CYCLES   8192

`endif

// [hdl/dac_mode_pkg.sv]
// types shared by the dac mode control block
// assumes nothing outside itself
package dac_mode_pkg;
    typedef enum logic [2:0] {
        FMT_LSB16, FMT_LSB20, FMT_MSB24, FMT_I2S, FMT_LSB24
    } format_t;
    typedef enum logic [2:0] {
        DEEMPH_OFF, DEEMPH_32K, DEEMPH_441K, DEEMPH_48K, DEEMPH_96K
    } deemph_t;
    typedef enum logic [1:0] {
        POWER_DOWN, WAIT_CLOCKS, WAIT_FRAME, RUNNING
    } power_t;
endpackage

// [hdl/edge_sync.sv]
// two-flop synchroniser with rise and fall detection
// assumes the input is asynchronous to clock
`timescale 1ns/1ps
module edge_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic resetN,
    // pin in
    input  wire logic pinIn,
    // synchronised level and edges
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;

    // first flop feeds only the second; level is a third flop, edges compare the second with level
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            level  <= 1'b1;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            level  <= sync_q;
        end
    end

    assign rise = sync_q & ~level;
    assign fall = ~sync_q & level;
endmodule

// [tb/dac_mode_control_checker.sv]
// port checks for the dac mode control block
// assumes one clock domain and the raw reset pin
`timescale 1ns/1ps
module dac_mode_control_checker
    import dac_mode_pkg::*;
#(
    parameter int RAMP_CYCLES = 1024
) (
    // clock and reset
    input wire logic                  clock,
    input wire logic                  rst_n,
    // pins
    input wire logic                  power_down_pin_n,
    input wire logic [2:0]            formatPins,
    input wire logic [2:0]            ratioPins,
    input wire logic                  speedPin,
    // outputs
    input wire dac_mode_pkg::format_t format_select,
    input wire logic [2:0]            clock_ratio_select,
    input wire logic [9:0]            ratioFs,
    input wire logic                  speed_select,
    input wire dac_mode_pkg::deemph_t deemphasis_select,
    input wire logic                  poweredUp,
    input wire logic                  timingRunN,
    input wire logic                  analogOutEnN,
    input wire logic [10:0]           attenuation,
    input wire logic                  muteDone
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // master clock ratio per code, zero where the speed forbids it
    function automatic logic [9:0] fsExp(input logic [2:0] r, input logic s);
        logic [9:0] nrm [8];
        logic [9:0] dbl [8];
        nrm = '{10'h100, 10'h100, 10'h180, 10'h180,
                10'h200, 10'h200, 10'h300, 10'h300};
        dbl = '{10'h080, 10'h100, 10'h0c0, 10'h180,
                10'h100, 10'h000, 10'h180, 10'h000};
        return s ? dbl[r] : nrm[r];
    endfunction
    // ****************
    // power and timing
    // ****************
    a_pwr_floats: assert property ((!power_down_pin_n)[*8] |-> analogOutEnN)
        else $error("outputs driven during power-down");
    a_pwr_halts: assert property ((!power_down_pin_n)[*8] |-> !poweredUp)
        else $error("running during power-down");
    a_timing_needs_run: assert property (timingRunN |-> poweredUp)
        else $error("timing runs while powered down");
    // ****************
    // mute ramp
    // ****************
    a_atten_bound: assert property (attenuation <= RAMP_CYCLES)
        else $error("attenuation beyond full mute");
    a_atten_step: assert property (poweredUp && $past(poweredUp) |->
        attenuation == $past(attenuation) ||
        attenuation == $past(attenuation) + 11'h1 ||
        attenuation + 11'h1 == $past(attenuation))
        else $error("attenuation moved more than one step");
    a_step_spacing: assert property ($changed(attenuation) && poweredUp |=>
        ($stable(attenuation) || !poweredUp)[*8])
        else $error("two steps within one frame");
    a_done_full: assert property (muteDone |-> attenuation >= RAMP_CYCLES - 1)
        else $error("mute done before full attenuation");
    // ****************
    // decoded settings
    // ****************
    a_ratio_fs: assert property ($stable(clock_ratio_select) &&
        $stable(speed_select) && $past(clock_ratio_select, 2) ==
        clock_ratio_select |-> ratioFs == fsExp(clock_ratio_select,
        speed_select))
        else $error("clock ratio decode wrong");
    a_deemph_double: assert property (speed_select && $past(speed_select) |->
        deemphasis_select inside {DEEMPH_OFF, DEEMPH_96K})
        else $error("double speed de-emphasis wrong");
    a_deemph_normal: assert property (!speed_select && !$past(speed_select)
        |-> deemphasis_select != DEEMPH_96K)
        else $error("normal speed gives 96k");
    a_format_pin: assert property (formatPins[2][*8] |->
        format_select == FMT_LSB24)
        else $error("format pin not ORed");
    a_speed_pin: assert property (speedPin[*8] |-> speed_select)
        else $error("speed pin not ORed");
    a_ratio_pin: assert property (ratioPins[2][*8] |->
        clock_ratio_select[2])
        else $error("ratio pin not ORed");
endmodule

bind dac_mode_control dac_mode_control_checker #(
    .RAMP_CYCLES(RAMP_CYCLES)
) dac_mode_control_checker_i (
    .clock(clock), .rst_n(rst_n), .power_down_pin_n(power_down_pin_n),
    .formatPins(formatPins), .ratioPins(ratioPins), .speedPin(speedPin),
    .format_select(format_select), .clock_ratio_select(clock_ratio_select),
    .ratioFs(ratioFs), .speed_select(speed_select),
    .deemphasis_select(deemphasis_select), .poweredUp(poweredUp),
    .timingRunN(timingRunN), .analogOutEnN(analogOutEnN),
    .attenuation(attenuation), .muteDone(muteDone)
);

// [tb/host_ctrl_model.sv]
// host side of the three-wire write-only control port
// assumes the bench calls sendFrame, one frame at a time
`timescale 1ns/1ps
module host_ctrl_model (
    // control port pins
    output logic control_select_n,
    output logic control_clock,
    output logic control_data_in
);
    // lines start high; select and clock stay high while no access runs, data keeps the inverted last bit
    initial begin
        control_select_n = 1'b1;
        control_clock    = 1'b1;
        control_data_in  = 1'b1;
    end
    // msb first; data moves on the falling edge, 200 ns bit period
    task automatic sendFrame(input logic [15:0] bits, input int nBits);
        control_select_n = 1'b0;
        #60;
        for (int i = 15; i > 15 - nBits; i--) begin
            control_clock   = 1'b0;
            control_data_in = bits[i];
            #100;
            control_clock = 1'b1;
            #100;
        end
        #60;
        control_select_n = 1'b1;
        control_data_in  = ~control_data_in; // released line holds no data
        #200;
    endtask
endmodule

// [tb/tb_dac_mode_control.sv]
// self-checking bench for the dac mode control block
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_dac_mode_control;
    import dac_mode_pkg::*;
    localparam int RAMP = 64;
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
        logic [2:0] fmt;
        logic [2:0] ratio;
        logic       spd;
        logic [2:0] dem;
    } row_t;
    logic clock, rst_n, power_down_pin_n, serialSelectN, masterClock;
    logic frame_clock, speedPin, mutePin, mclkRun;
    logic control_select_n, control_clock, control_data_in;
    logic [2:0] formatPins, ratioPins;
    logic [1:0] deemphPins;
    format_t format_select;
    deemph_t deemphasis_select;
    logic [2:0] clock_ratio_select;
    logic [9:0] ratioFs;
    logic speed_select, poweredUp, timingRunN, analogOutEnN, muteDone;
    logic [10:0] attenuation;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    // ****************
    // rows: address, data, format, ratio, speed, de-emphasis
    // ****************
    row_t rows [17] = '{
        '{5'h00, 8'h03, 3'd1, 3'd0, 1'b0, 3'd2}, '{5'h00, 8'h15, 3'd2, 3'd1, 1'b0, 3'd2},
        '{5'h00, 8'h27, 3'd3, 3'd2, 1'b0, 3'd2}, '{5'h00, 8'h39, 3'd4, 3'd3, 1'b0, 3'd2},
        '{5'h00, 8'h71, 3'd0, 3'd7, 1'b0, 3'd2}, '{5'h00, 8'hff, 3'd4, 3'd7, 1'b0, 3'd2},
        '{5'h01, 8'h00, 3'd4, 3'd7, 1'b0, 3'd2}, '{5'h01, 8'h02, 3'd4, 3'd7, 1'b0, 3'd0},
        '{5'h01, 8'h04, 3'd4, 3'd7, 1'b0, 3'd3}, '{5'h01, 8'h06, 3'd4, 3'd7, 1'b0, 3'd1},
        '{5'h01, 8'h0c, 3'd4, 3'd7, 1'b1, 3'd4}, '{5'h01, 8'h08, 3'd4, 3'd7, 1'b1, 3'd0},
        '{5'h01, 8'h0e, 3'd4, 3'd7, 1'b1, 3'd0}, '{5'h01, 8'hf0, 3'd4, 3'd7, 1'b0, 3'd2},
        '{5'h00, 8'h41, 3'd0, 3'd4, 1'b0, 3'd2}, '{5'h00, 8'h51, 3'd0, 3'd5, 1'b0, 3'd2},
        '{5'h00, 8'h61, 3'd0, 3'd6, 1'b0, 3'd2}};
    // frames that must leave the mode unchanged: short, bad prefixes, test and spare space
    logic [15:0] badBits [5] = '{16'h6003, 16'h4003, 16'h2003, 16'h6203, 16'h6303};
    int badLen [5] = '{15, 16, 16, 16, 16};

    dac_mode_control #(.RAMP_CYCLES(RAMP), .MCLK_TIMEOUT(64),
        .FCLK_TIMEOUT(64)) dac_mode_control_i (.*);
    host_ctrl_model host_ctrl_model_i (.control_select_n(control_select_n),
        .control_clock(control_clock), .control_data_in(control_data_in));

    // clocks: system 5 ns, master clock gated, frame clock 80 ns
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always #7 if (mclkRun) masterClock = ~masterClock;
    always #40 frame_clock = ~frame_clock;
    // hang guard, well above the expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [9:0] fsOf(input logic [2:0] r, input logic s);
        logic [9:0] nrm [8];
        logic [9:0] dbl [8];
        nrm = '{10'h100, 10'h100, 10'h180, 10'h180, 10'h200, 10'h200, 10'h300, 10'h300};
        dbl = '{10'h080, 10'h100, 10'h0c0, 10'h180, 10'h100, 10'h000, 10'h180, 10'h000};
        return s ? dbl[r] : nrm[r];
    endfunction
    task automatic mode(input logic [2:0] f, r, input logic s, input logic [2:0] d);
        chk("format", 16'(f), 16'(format_select));
        chk("ratio", 16'(r), 16'(clock_ratio_select));
        chk("ratioFs", 16'(fsOf(r, s)), 16'(ratioFs));
        chk("speed", 16'(s), 16'(speed_select));
        chk("deemph", 16'(d), 16'(deemphasis_select));
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host_ctrl_model_i.sendFrame({2'b01, 1'b1, a, d}, 16);
        cyc(12);
    endtask
    task automatic waitUp();
        for (int i = 0; i < 600 && poweredUp !== 1'b1; i++) cyc(1);
        chk("poweredUp", 16'h1, 16'(poweredUp));
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        {rst_n, masterClock, frame_clock, speedPin, mutePin} = 5'h0;
        {power_down_pin_n, mclkRun, serialSelectN} = 3'b110;
        {formatPins, ratioPins, deemphPins} = 8'h00;
        repeat (5) @(posedge clock);
        #1 rst_n = 1'b1;
        waitUp();
        mode(0, 0, 0, 2);
        chk("timingRunN", 16'h1, 16'(timingRunN));
        chk("outEnN", 16'h0, 16'(analogOutEnN));
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].data);
            mode(rows[i].fmt, rows[i].ratio, rows[i].spd, rows[i].dem);
        end
        for (int i = 0; i < 5; i++) begin
            host_ctrl_model_i.sendFrame(badBits[i], badLen[i]);
            cyc(12);
            mode(0, 6, 0, 2);
        end
        wr(5'h00, 8'h24);
        chk("timingRunN", 16'h0, 16'(timingRunN));
        mode(2, 2, 0, 2);
        wr(5'h00, 8'h25);
        chk("timingRunN", 16'h1, 16'(timingRunN));
        {formatPins, ratioPins, speedPin} = 7'b1011001;
        cyc(12);
        mode(4, 6, 1, 0);
        {formatPins, ratioPins, speedPin} = 7'h00;
        wr(5'h01, 8'h01);
        cyc(280);
        chk("rampRate", 16'h1, 16'(attenuation > 18 && attenuation < 23));
        cyc(RAMP * 16);
        chk("atten", 16'(RAMP), 16'(attenuation));
        chk("muteDone", 16'h1, 16'(muteDone));
        wr(5'h01, 8'h00);
        cyc(RAMP * 16 + 40);
        chk("atten", 16'h0, 16'(attenuation));
        wr(5'h01, 8'h01);
        wr(5'h01, 8'h00);
        chk("cancel", 16'h1, 16'(attenuation > 30 && attenuation < RAMP));
        chk("muteDone", 16'h0, 16'(muteDone));
        cyc(RAMP * 16 + 40);
        chk("atten", 16'h0, 16'(attenuation));
        mclkRun = 1'b0;
        cyc(100);
        chk("poweredUp", 16'h0, 16'(poweredUp));
        wr(5'h00, 8'h03);
        mclkRun = 1'b1;
        waitUp();
        mode(2, 2, 0, 2);
        power_down_pin_n = 1'b0;
        cyc(20);
        chk("outEnN", 16'h1, 16'(analogOutEnN));
        wr(5'h01, 8'h0c);
        power_down_pin_n = 1'b1;
        waitUp();
        mode(0, 0, 0, 2);
        {serialSelectN, deemphPins, mutePin} = 4'b1101;
        cyc(12);
        wr(5'h00, 8'h03);
        mode(0, 0, 0, 3);
        chk("pinMute", 16'h1, 16'(attenuation > 30));
        wrap_up();
    end
endmodule
